// ### include/lac_regs.vh
// Port addresses, field positions and reset values of the legacy compatibility ports
`ifndef LAC_REGS_VH
`define LAC_REGS_VH
`define LAC_PORT_MONO_MODE 10'h3b8
`define LAC_PORT_MONO_PRESET 10'h3b9
`define LAC_PORT_MONO_STATUS 10'h3ba
`define LAC_PORT_MONO_CLEAR 10'h3bb
`define LAC_PORT_MONO_GFX 10'h3bf
`define LAC_PORT_COLOR_MODE 10'h3d8
`define LAC_PORT_COLOR_SEL 10'h3d9
`define LAC_PORT_COLOR_STATUS 10'h3da
`define LAC_PORT_COLOR_CLEAR 10'h3db
`define LAC_PORT_COLOR_PRESET 10'h3dc
`define LAC_MODE_HIRES 0
`define LAC_MODE_GFX_OVR 1
`define LAC_MODE_80COL 0
`define LAC_MODE_GFX320 1
`define LAC_MODE_VIDEO 3
`define LAC_MODE_BW640 4
`define LAC_MODE_BLINK 5
`define LAC_MODE_PAGE 7
`define LAC_GFX_ENABLE 0
`define LAC_GFX_UPPER 1
`define LAC_SEL_ALT 4
`define LAC_SEL_PALETTE 5
`define LAC_MONO_MODE_MASK 8'hab
`define LAC_COLOR_MODE_MASK 8'h3f
`define LAC_COLOR_SEL_MASK 8'h3f
`define LAC_RESET_BYTE 8'h00
`define LAC_RESET_GFX 2'h0
`endif

// ### core/lac_sync2.v
// Two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module lac_sync2 #(
  parameter WIDTH = 4
) (
  core_clk,
  rst_n,
  async_in,
  sync_out
);
  input wire core_clk;
  input wire rst_n;
  input wire [WIDTH-1:0] async_in;
  output wire [WIDTH-1:0] sync_out;
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;
  // First stage feeds only the second
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end
  assign sync_out = sync_r;
endmodule // lac_sync2

// ### core/lac_compat_regs.v
// Legacy mono/color adapter compatibility port bank
// Notes on behaviour
// R01: Mono mode bit 7 picks display page when override and graphics enable set.
// R02: Bit 5 of both mode ports enables character blink.
// R03: Bit 3 of both mode ports enables video; zero suppresses video.
// R04: Mono bit 1 clear blocks setting graphics-enable bits, forcing alpha.
// R05: Software writes mono bit 0 as one for high resolution.
// R06: Graphics-enable port is two bits, used only in legacy mode.
// R07: Graphics-enable bit 1 clear blocks host access to upper page.
// R08: Graphics-enable bit 0 permits graphics, subject to mono override bit.
// R09: Color mode bit 4 selects 640x200 black-and-white graphics.
// R10: Color mode bit 1 selects 320x200 graphics over text.
// R11: Color mode bit 0 selects 80 columns, else 40 columns.
// R12: Color select bit 5 picks the 320x200 palette set.
// R13: Color select bit 4 enables alternate color set / alpha background; code zeroes the alpha background when bit 4 is set.
// R14: Color select bits 3:0 give IRGB border or background color.
// R15: In 640x200 mode low color bits give foreground color.
// R16: Mono status bit 7 reads zero during vertical retrace.
// R17: Status bit 0 reads one during border or blanking.
// R18: Color status bit 3 reads one during vertical retrace.
// R19: Color status bit 2 reads zero while light-pen switch closed.
// R20: Color status bit 1 shows the light-pen latch.
// R21: Mono status bit 3 shows black-and-white video enabled.
// R22: Ports decode only while legacy mode is selected.
// R23: Misc output bit 0 chooses mono or color port base.
// R24: Preset port access sets light-pen latch; clear port clears it.
// R25: Reserved write bits ignored; reserved status bits read zero.
// R26: All control bits clear to zero on reset.
`timescale 1ns/1ps
`include "lac_regs.vh"
module lac_compat_regs (
  core_clk,
  rst_n,
  io_addr,
  io_wdata,
  io_wr,
  io_rd,
  io_rdata,
  io_hit,
  video_select_legacy,
  misc_color_base,
  vretrace_in,
  display_enable_in,
  lpen_switch_in,
  lpen_trigger_in,
  host_mem_addr,
  host_mem_block,
  mono_text_adapter_mode,
  color_graphics_adapter_mode,
  video_enable,
  blink_enable,
  high_res,
  mono_graphics,
  display_page_b800,
  text_80col,
  graphics_320,
  graphics_640,
  palette_cyan_set,
  alt_color_set,
  border_irgb,
  background_irgb,
  foreground_irgb
);
  input wire core_clk;
  input wire rst_n;
  input wire [9:0] io_addr;
  input wire [7:0] io_wdata;
  input wire io_wr;
  input wire io_rd;
  output reg [7:0] io_rdata;
  output wire io_hit;
  input wire video_select_legacy;
  input wire misc_color_base;
  input wire vretrace_in;
  input wire display_enable_in;
  input wire lpen_switch_in;
  input wire lpen_trigger_in;
  input wire [15:0] host_mem_addr;
  output wire host_mem_block;
  output wire mono_text_adapter_mode;
  output wire color_graphics_adapter_mode;
  output reg video_enable;
  output reg blink_enable;
  output reg high_res;
  output reg mono_graphics;
  output reg display_page_b800;
  output reg text_80col;
  output reg graphics_320;
  output reg graphics_640;
  output reg palette_cyan_set;
  output reg alt_color_set;
  output reg [3:0] border_irgb;
  output reg [3:0] background_irgb;
  output reg [3:0] foreground_irgb;

  reg [7:0] mono_mode_r;
  reg [1:0] mono_gfx_r;
  reg [7:0] color_mode_r;
  reg [7:0] color_sel_r;
  reg lpen_latch_r;
  reg [1:0] mono_gfx_nxt;
  reg [7:0] io_rdata_nxt;
  wire [3:0] pin_sync;
  wire vretrace_s;
  wire de_s;
  wire lpen_sw_s;
  wire lpen_trig_s;
  wire mono_act;
  wire color_act;
  wire mono_gfx_on;

  // Port match, qualified by legacy mode and the mono/color base
  function port_match;
    input [9:0] addr;
    input [9:0] port;
    input base_ok;
    begin
      port_match = video_select_legacy && base_ok && (addr == port); // R22
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  lac_sync2 #(
    .WIDTH(4)
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in({vretrace_in, display_enable_in, lpen_switch_in, lpen_trigger_in}),
    .sync_out(pin_sync)
  );
  assign vretrace_s = pin_sync[3];
  assign de_s = pin_sync[2];
  assign lpen_sw_s = pin_sync[1];
  assign lpen_trig_s = pin_sync[0];

  assign mono_act = !misc_color_base; // R23
  assign color_act = misc_color_base; // R23
  assign mono_text_adapter_mode = video_select_legacy & mono_act;
  assign color_graphics_adapter_mode = video_select_legacy & color_act;

  wire wr_mono_mode = io_wr && port_match(io_addr, `LAC_PORT_MONO_MODE, mono_act);
  wire wr_mono_gfx = io_wr && port_match(io_addr, `LAC_PORT_MONO_GFX, 1'b1);
  wire wr_color_mode = io_wr && port_match(io_addr, `LAC_PORT_COLOR_MODE, color_act);
  wire wr_color_sel = io_wr && port_match(io_addr, `LAC_PORT_COLOR_SEL, 1'b1);
  wire acc = io_wr || io_rd;
  wire lpen_preset = acc && (port_match(io_addr, `LAC_PORT_MONO_PRESET, mono_act) ||
    port_match(io_addr, `LAC_PORT_COLOR_PRESET, color_act));
  wire lpen_clear = acc && (port_match(io_addr, `LAC_PORT_MONO_CLEAR, mono_act) ||
    port_match(io_addr, `LAC_PORT_COLOR_CLEAR, color_act));
  wire rd_mono_st = port_match(io_addr, `LAC_PORT_MONO_STATUS, mono_act);
  wire rd_color_st = port_match(io_addr, `LAC_PORT_COLOR_STATUS, color_act);

  assign io_hit = wr_mono_mode || wr_mono_gfx || wr_color_mode || wr_color_sel ||
    lpen_preset || lpen_clear || (io_rd && (rd_mono_st || rd_color_st));

  ////////////////////////////////////////////////////////////////////////
  // Write-only ports
  // Override bit blocks setting the graphics bits; clearing is still allowed
  always @* begin
    mono_gfx_nxt = mono_gfx_r;
    if (wr_mono_gfx) begin
      if (mono_mode_r[`LAC_MODE_GFX_OVR]) begin
        mono_gfx_nxt = io_wdata[1:0]; // R06
      end else begin
        mono_gfx_nxt = mono_gfx_r & io_wdata[1:0]; // R04
      end
    end
    if (wr_mono_mode && !io_wdata[`LAC_MODE_GFX_OVR]) begin
      mono_gfx_nxt = `LAC_RESET_GFX; // R04
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mono_mode_r <= `LAC_RESET_BYTE; // R26
      mono_gfx_r <= `LAC_RESET_GFX; // R26
      color_mode_r <= `LAC_RESET_BYTE; // R26
      color_sel_r <= `LAC_RESET_BYTE; // R26
    end else begin
      if (wr_mono_mode) begin
        mono_mode_r <= io_wdata & `LAC_MONO_MODE_MASK; // R25
      end
      mono_gfx_r <= mono_gfx_nxt;
      if (wr_color_mode) begin
        color_mode_r <= io_wdata & `LAC_COLOR_MODE_MASK; // R25
      end
      if (wr_color_sel) begin
        color_sel_r <= io_wdata & `LAC_COLOR_SEL_MASK; // R25
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Light-pen latch; a trigger in the clearing cycle wins
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lpen_latch_r <= 1'b0;
    end else if (lpen_preset || lpen_trig_s) begin
      lpen_latch_r <= 1'b1; // R24
    end else if (lpen_clear) begin
      lpen_latch_r <= 1'b0; // R24
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status reads
  always @* begin
    io_rdata_nxt = 8'h00; // R25
    if (io_rd && rd_mono_st) begin
      io_rdata_nxt[7] = !vretrace_s; // R16
      io_rdata_nxt[3] = mono_mode_r[`LAC_MODE_VIDEO]; // R21
      io_rdata_nxt[0] = !de_s; // R17
    end else if (io_rd && rd_color_st) begin
      io_rdata_nxt[3] = vretrace_s; // R18
      io_rdata_nxt[2] = lpen_sw_s; // R19
      io_rdata_nxt[1] = lpen_latch_r; // R20
      io_rdata_nxt[0] = !de_s; // R17
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata <= 8'h00;
    end else begin
      io_rdata <= io_rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decoded display controls
  assign mono_gfx_on = mono_mode_r[`LAC_MODE_GFX_OVR] && mono_gfx_r[`LAC_GFX_ENABLE]; // R08

  // Upper page lies at B800:0 offset 8000 in the 64 Kbyte window
  assign host_mem_block = mono_text_adapter_mode && host_mem_addr[15] &&
    !mono_gfx_r[`LAC_GFX_UPPER]; // R07

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      video_enable <= 1'b0;
      blink_enable <= 1'b0;
      high_res <= 1'b0;
      mono_graphics <= 1'b0;
      display_page_b800 <= 1'b0;
      text_80col <= 1'b0;
      graphics_320 <= 1'b0;
      graphics_640 <= 1'b0;
      palette_cyan_set <= 1'b0;
      alt_color_set <= 1'b0;
      border_irgb <= 4'h0;
      background_irgb <= 4'h0;
      foreground_irgb <= 4'h0;
    end else if (!video_select_legacy) begin
      video_enable <= 1'b0; // R22
      blink_enable <= 1'b0;
      high_res <= 1'b0;
      mono_graphics <= 1'b0; // R06
      display_page_b800 <= 1'b0;
      text_80col <= 1'b0;
      graphics_320 <= 1'b0;
      graphics_640 <= 1'b0;
      palette_cyan_set <= 1'b0;
      alt_color_set <= 1'b0;
      border_irgb <= 4'h0;
      background_irgb <= 4'h0;
      foreground_irgb <= 4'h0;
    end else if (mono_act) begin
      video_enable <= mono_mode_r[`LAC_MODE_VIDEO]; // R03
      blink_enable <= mono_mode_r[`LAC_MODE_BLINK]; // R02
      high_res <= mono_mode_r[`LAC_MODE_HIRES]; // R05
      mono_graphics <= mono_gfx_on; // R04
      display_page_b800 <= mono_gfx_on && mono_mode_r[`LAC_MODE_PAGE]; // R01
      text_80col <= 1'b1;
      graphics_320 <= 1'b0;
      graphics_640 <= 1'b0;
      palette_cyan_set <= 1'b0;
      alt_color_set <= 1'b0;
      border_irgb <= 4'h0;
      background_irgb <= 4'h0;
      foreground_irgb <= 4'h0;
    end else begin
      video_enable <= color_mode_r[`LAC_MODE_VIDEO]; // R03
      blink_enable <= color_mode_r[`LAC_MODE_BLINK]; // R02
      high_res <= 1'b0;
      mono_graphics <= 1'b0;
      display_page_b800 <= 1'b0;
      text_80col <= color_mode_r[`LAC_MODE_80COL]; // R11
      graphics_320 <= color_mode_r[`LAC_MODE_GFX320]; // R10
      graphics_640 <= color_mode_r[`LAC_MODE_BW640]; // R09
      palette_cyan_set <= color_sel_r[`LAC_SEL_PALETTE]; // R12
      alt_color_set <= color_sel_r[`LAC_SEL_ALT]; // R13
      if (color_mode_r[`LAC_MODE_BW640]) begin
        foreground_irgb <= color_sel_r[3:0]; // R15
        border_irgb <= 4'h0;
        background_irgb <= 4'h0;
      end else if (color_mode_r[`LAC_MODE_GFX320]) begin
        border_irgb <= color_sel_r[3:0]; // R14
        background_irgb <= color_sel_r[3:0]; // R14
        foreground_irgb <= 4'h0;
      end else begin
        border_irgb <= color_sel_r[3:0]; // R14
        // Alpha background applies only with bit 4 clear; set means alternate set
        background_irgb <= !color_sel_r[`LAC_SEL_ALT] ? color_sel_r[3:0] : 4'h0; // R13
        foreground_irgb <= 4'h0;
      end
    end
  end
endmodule // lac_compat_regs

// ### dv/lac_compat_monitor.sv
// Port-level assertions for the legacy compatibility port bank
`timescale 1ns/1ps
module lac_compat_monitor (
  input logic core_clk,
  input logic rst_n,
  input logic [9:0] io_addr,
  input logic [7:0] io_wdata,
  input logic io_wr,
  input logic io_rd,
  input logic [7:0] io_rdata,
  input logic io_hit,
  input logic video_select_legacy,
  input logic misc_color_base,
  input logic [15:0] host_mem_addr,
  input logic host_mem_block,
  input logic video_enable,
  input logic mono_graphics,
  input logic display_page_b800,
  input logic graphics_640,
  input logic [3:0] foreground_irgb
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_cmode_wr;
    io_wr && io_hit && io_addr == 10'h3d8 && misc_color_base;
  endsequence
  sequence s_legacy_off2;
    !video_select_legacy ##1 !video_select_legacy;
  endsequence
  chk_cmode_video: assert property (s_cmode_wr ##1 (video_select_legacy && misc_color_base)
    |=> video_enable == $past(io_wdata[3], 2)) else $error("video enable not from write");
  chk_legacy_hit: assert property (!video_select_legacy |-> !io_hit)
    else $error("port decoded outside legacy mode");
  chk_legacy_outs: assert property (s_legacy_off2 |-> !video_enable && !mono_graphics)
    else $error("control output set outside legacy mode");
  chk_mono_base: assert property (!misc_color_base && io_addr == 10'h3da |-> !io_hit)
    else $error("color status decoded in mono base");
  chk_color_base: assert property (misc_color_base && io_addr == 10'h3ba |-> !io_hit)
    else $error("mono status decoded in color base");
  chk_rd_idle: assert property (!io_rd |=> io_rdata == 8'h00)
    else $error("read data not idle");
  chk_mono_rsvd: assert property (io_rd && io_hit && io_addr == 10'h3ba
    |=> io_rdata[6:4] == 3'h0 && io_rdata[2:1] == 2'h0) else $error("mono status reserved set");
  chk_page_gate: assert property (display_page_b800 |-> mono_graphics)
    else $error("page select outside mono graphics");
  chk_upper_page: assert property (host_mem_block |-> host_mem_addr[15])
    else $error("lower page blocked");
  chk_fg_mode: assert property (foreground_irgb != 4'h0 |-> graphics_640)
    else $error("foreground outside 640 mode");
endmodule // lac_compat_monitor
////////////////////////////////////////////////////////////
bind lac_compat_regs lac_compat_monitor u_mon (.core_clk(core_clk), .rst_n(rst_n),
  .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
  .io_hit(io_hit), .video_select_legacy(video_select_legacy), .misc_color_base(misc_color_base),
  .host_mem_addr(host_mem_addr), .host_mem_block(host_mem_block), .video_enable(video_enable),
  .mono_graphics(mono_graphics), .display_page_b800(display_page_b800),
  .graphics_640(graphics_640), .foreground_irgb(foreground_irgb));

// ### dv/tb.sv
// Self-checking bench for the legacy compatibility port bank
`timescale 1ns/1ps
module tb;
  logic core_clk = 0, rst_n = 0, io_wr = 0, io_rd = 0, leg = 1, cb = 1;
  logic [9:0] io_addr = 0;
  logic [7:0] io_wdata = 0, io_rdata, ev;
  logic vr = 0, de = 0, sw = 0, lpt = 0, io_hit, blk;
  logic [15:0] ma = 0;
  logic ve, bl, hr, mg, pg, t80, g32, g64, pal, alt, mtm, cgm;
  logic [3:0] brd, bkg, fg;
  int num_errors = 0, check_count = 0;
  int mm = 0, gx = 0, cm = 0, cs = 0, lat = 0, seed, i;
  always #20 core_clk = ~core_clk;
  lac_compat_regs u_dut (.core_clk(core_clk), .rst_n(rst_n), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .io_hit(io_hit),
    .video_select_legacy(leg), .misc_color_base(cb), .vretrace_in(vr), .display_enable_in(de),
    .lpen_switch_in(sw), .lpen_trigger_in(lpt), .host_mem_addr(ma), .host_mem_block(blk),
    .mono_text_adapter_mode(mtm), .color_graphics_adapter_mode(cgm), .video_enable(ve),
    .blink_enable(bl), .high_res(hr), .mono_graphics(mg), .display_page_b800(pg),
    .text_80col(t80), .graphics_320(g32), .graphics_640(g64), .palette_cyan_set(pal),
    .alt_color_set(alt), .border_irgb(brd), .background_irgb(bkg), .foreground_irgb(fg));
  ////////////////////////////////////////////////////////////
  task stop_test;
    if (num_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] a, input logic [7:0] e);
    check_count++;
    if (a !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, a, e);
    end
  endtask
  // One strobe cycle; the model follows the same decode
  task acc(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(negedge core_clk);
    io_addr = a;
    io_wdata = d;
    io_wr = w;
    io_rd = !w;
    @(negedge core_clk);
    io_wr = 0;
    io_rd = 0;
    if (leg && (a == 10'h3bf || a == 10'h3d9 || a[7:4] == (cb ? 4'hd : 4'hb))) begin
      if (w && a == 10'h3b8) mm = d & 8'hab;
      if (w && a == 10'h3b8 && !d[1]) gx = 0;
      if (w && a == 10'h3bf) gx = mm[1] ? d & 3 : 0;
      if (w && a == 10'h3d8) cm = d & 8'h3f;
      if (w && a == 10'h3d9) cs = d & 8'h3f;
      if (a == 10'h3b9 || a == 10'h3dc) lat = 1;
      if (a[3:0] == 4'hb) lat = 0;
    end
  endtask
  task rd(input logic [9:0] a, input logic [7:0] e);
    acc(0, a, 8'h00);
    chk(io_rdata, e);
  endtask
  task cchk;
    repeat (2) @(negedge core_clk);
    ev = {cm[3], cm[5], cm[0], cm[1], cm[4], cs[5], cs[4], leg & cb};
    chk({ve, bl, t80, g32, g64, pal, alt, cgm}, ev);
    ev = cm[4] ? 8'h00 : {cs[3:0], (cm[1] || !cs[4]) ? cs[3:0] : 4'h0};
    chk({brd, bkg}, ev);
    chk({4'h0, fg}, cm[4] ? cs[3:0] : 8'h00);
  endtask
  task mchk;
    repeat (2) @(negedge core_clk);
    ev = {mm[3], mm[5], mm[0], mm[1] & gx[0], mm[7] & mm[1] & gx[0], ma[15] & !gx[1],
      leg & !cb, leg & cb};
    chk({ve, bl, hr, mg, pg, blk, mtm, cgm}, ev);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    num_errors++;
    stop_test;
  end
  initial begin
    seed = $urandom(32);
    repeat (16) @(negedge core_clk);
    rst_n = 1;
    chk({ve, bl, hr, mg, pg, t80, g64, alt}, 8'h00);
    chk({brd, fg}, 8'h00);
    for (i = 0; i < 12; i++) begin
      {vr, de, sw} = 3'($urandom);
      acc(1, 10'h3d8, 8'($urandom));
      acc(1, 10'h3d9, 8'($urandom));
      cchk;
      rd(10'h3da, {4'h0, vr, sw, lat[0], ~de});
    end
    lpt = 1;
    repeat (4) @(negedge core_clk);
    lpt = 0;
    lat = 1;
    repeat (3) @(negedge core_clk);
    rd(10'h3da, {4'h0, vr, sw, lat[0], ~de});
    acc(1, 10'h3db, 8'h00);
    rd(10'h3da, {4'h0, vr, sw, lat[0], ~de});
    acc(0, 10'h3dc, 8'h00);
    rd(10'h3da, {4'h0, vr, sw, lat[0], ~de});
    // Legacy off must freeze the registers, not clear them
    acc(1, 10'h3d8, 8'h3b);
    leg = 0;
    acc(1, 10'h3d8, 8'h00);
    repeat (2) @(negedge core_clk);
    chk({ve, bl, t80, g32, g64, pal, alt, mg}, 8'h00);
    leg = 1;
    cchk;
    cb = 0;
    ma = 16'h8000;
    acc(1, 10'h3d8, 8'h00);
    acc(1, 10'h3b8, 8'hfd);
    acc(1, 10'h3bf, 8'h03);
    mchk;
    acc(1, 10'h3b8, 8'h8b);
    acc(1, 10'h3bf, 8'h03);
    mchk;
    acc(1, 10'h3bf, 8'h01);
    mchk;
    rd(10'h3ba, {~vr, 3'h0, mm[3], 2'h0, ~de});
    acc(1, 10'h3b8, 8'h09);
    mchk;
    rd(10'h3b0, 8'h00);
    // Mono latch ports act in mono base; the color preset is refused there
    acc(1, 10'h3bb, 8'h00);
    acc(0, 10'h3dc, 8'h00);
    cb = 1;
    rd(10'h3da, {4'h0, vr, sw, lat[0], ~de});
    cb = 0;
    acc(0, 10'h3b9, 8'h00);
    cb = 1;
    rd(10'h3da, {4'h0, vr, sw, lat[0], ~de});
    stop_test;
  end
endmodule // tb
